// File: scg_regs.vh
`ifndef SCG_REGS_VH
`define SCG_REGS_VH

// Register byte offsets
`define SCG_REG_CTRL      8'h00
`define SCG_REG_STATUS    8'h04
`define SCG_REG_JTAG      8'h08
`define SCG_REG_WORDS     8'h0c

// Control register fields and reset value
`define SCG_CTRL_ENC      0
`define SCG_CTRL_AUTH     1
`define SCG_CTRL_WID_LO   4
`define SCG_CTRL_WID_HI   6
`define SCG_CTRL_START    8
`define SCG_CTRL_RESET    32'h00000000
`define SCG_CTRL_MASK     32'h00000073

// Status register fields
`define SCG_ST_STATE_LO   0
`define SCG_ST_STATE_HI   7
`define SCG_ST_USER       8
`define SCG_ST_HALT       9
`define SCG_ST_LOCK       10
`define SCG_ST_SUPPLY     11
`define SCG_ST_ERR_LO     16
`define SCG_ST_ERR_HI     22

// Halt reason bits, offsets within the error field
`define SCG_ERR_COMP      0
`define SCG_ERR_WIDE      1
`define SCG_ERR_MISMATCH  2
`define SCG_ERR_PKH       3
`define SCG_ERR_SIG       4
`define SCG_ERR_OVF       5
`define SCG_ERR_LEN       6
`define SCG_ERR_BITS      7

// Stream header word fields
`define SCG_HDR_ENC       0
`define SCG_HDR_SIGN      1
`define SCG_HDR_COMP      2

// Passive width codes that security forbids
`define SCG_WID_X16       3'h4
`define SCG_WID_X32       3'h5

// Instruction codes still served under the lock
`define SCG_JI_IDCODE     4'h1
`define SCG_JI_STATUS     4'h2
`define SCG_JI_BYPASS     4'hf

// Key and digest constants
`define SCG_KEY_BITS      256
`define SCG_MIX_SEED      32'h5a17c3e9

`endif

// File: scg_sync.v
`default_nettype none

module scg_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         hclk,
   input  wire         hresetn,
   // Asynchronous inputs
   input  wire [W-1:0] d,
   // Second and third stages
   output wire [W-1:0] s2,
   output wire [W-1:0] s3
);

   reg [W-1:0] st1_r;
   reg [W-1:0] st2_r;
   reg [W-1:0] st3_r;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st1_r <= {W{1'b0}};
         st2_r <= {W{1'b0}};
         st3_r <= {W{1'b0}};
      end else begin
         st1_r <= d;
         st2_r <= st1_r;
         st3_r <= st2_r;
      end
   end

   assign s2 = st2_r;
   assign s3 = st3_r;

endmodule // scg_sync

`default_nettype wire

// File: scg_fifo.v
`default_nettype none

// Pointers wrap by width, so DEPTH must equal 2**AW
module scg_fifo #(
   parameter W     = 32,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   // Clock and reset
   input  wire         hclk,
   input  wire         hresetn,
   input  wire         flush,
   // Fill side
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   // Drain side
   output reg          out_valid,
   input  wire         out_ready,
   output reg  [W-1:0] out_data
);

   localparam [AW:0] FULL = DEPTH[AW:0];

   reg  [W-1:0]  mem [0:DEPTH-1];
   reg  [AW-1:0] wptr_r;
   reg  [AW-1:0] rptr_r;
   reg  [AW:0]   count_r;
   wire          push;
   wire          pop;

   assign in_ready = (count_r != FULL);
   assign push     = in_valid & in_ready;
   // Output stage refills as soon as it empties
   assign pop      = (count_r != {(AW+1){1'b0}}) & (~out_valid | out_ready);

   always @(posedge hclk) begin
      if (push) begin
         mem[wptr_r] <= in_data;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wptr_r    <= {AW{1'b0}};
         rptr_r    <= {AW{1'b0}};
         count_r   <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data  <= {W{1'b0}};
      end else if (flush) begin
         wptr_r    <= {AW{1'b0}};
         rptr_r    <= {AW{1'b0}};
         count_r   <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + 1'b1;
         end
         if (pop) begin
            rptr_r    <= rptr_r + 1'b1;
            out_data  <= mem[rptr_r];
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
         if (push & ~pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop & ~push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule // scg_fifo

`default_nettype wire

// File: scg_gate.v
// Behaviour
// - Decrypt payload words with a keystream derived from the 256-bit fused key.
// - Encryption and authentication are enabled separately; either, both or none.
// - A compressed stream with any security feature enabled halts configuration.
// - With authentication on, a digest is built while words arrive and checked against the stream's signature after the last data word.
// - Public key comes from the stream; only its hash is held in fuses.
// - Good signature: configuration finishes and user mode is entered.
// - Bad signature: configuration halts and user mode is never entered.
// - Locked: only identification, status readout and bypass instructions are accepted.
// - The lock cannot be undone by any register or instruction.
// - With security on, the 16-bit and 32-bit passive widths are refused.
`include "scg_regs.vh"
`default_nettype none

module scg_gate #(
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW    = 5
) (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg  [31:0] hrdata,
   output reg         hresp,
   // Serial bitstream link pins
   input  wire        cfg_sclk,
   input  wire        cfg_sdata,
   // Fuse block
   input  wire [255:0] fuse_aes_key,
   input  wire [31:0] fuse_pubkey_hash,
   input  wire        fuse_jtag_lock,
   input  wire        fuse_program_supply,
   // Instruction decoder of the test port
   input  wire        jtag_ir_update,
   input  wire [3:0]  jtag_ir_code,
   output reg  [3:0]  jtag_ir_active,
   output reg         jtag_ir_reject,
   // Configuration memory side
   output reg  [31:0] cfg_word,
   output reg         cfg_word_valid,
   output reg         user_mode,
   output reg         cfg_halted
);

   localparam [7:0] ST_IDLE = 8'h01;
   localparam [7:0] ST_HDR  = 8'h02;
   localparam [7:0] ST_LEN  = 8'h04;
   localparam [7:0] ST_PKH  = 8'h08;
   localparam [7:0] ST_DATA = 8'h10;
   localparam [7:0] ST_SIG  = 8'h20;
   localparam [7:0] ST_USER = 8'h40;
   localparam [7:0] ST_HALT = 8'h80;

   // Rotate-xor-add mixer shared by keystream, key hash and digest
   function [31:0] scg_mix;
      input [31:0] a;
      input [31:0] b;
      begin
         scg_mix = {a[26:0], a[31:27]} ^ (b + {b[18:0], b[31:19]} + `SCG_MIX_SEED);
      end
   endfunction

   function [31:0] key_word;
      input [255:0] key;
      input [2:0]   idx;
      begin
         key_word = key[{idx, 5'h00} +: 32];
      end
   endfunction

   function is_public_ir;
      input [3:0] code;
      begin
         is_public_ir = (code == `SCG_JI_IDCODE) | (code == `SCG_JI_STATUS) |
                        (code == `SCG_JI_BYPASS);
      end
   endfunction

   // Pin synchronisers
   wire [2:0] pin_s2;
   wire [2:0] pin_s3;

   scg_sync #(.W(3)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({fuse_program_supply, cfg_sdata, cfg_sclk}),
      .s2      (pin_s2),
      .s3      (pin_s3)
   );

   reg  [2:0]  pin_lvl_r;
   reg  [2:0]  pin_lvl_nxt;
   wire        sclk_rise;

   always @* begin
      pin_lvl_nxt = pin_lvl_r;
      if (pin_s2[0] == pin_s3[0]) pin_lvl_nxt[0] = pin_s3[0];
      if (pin_s2[1] == pin_s3[1]) pin_lvl_nxt[1] = pin_s3[1];
      if (pin_s2[2] == pin_s3[2]) pin_lvl_nxt[2] = pin_s3[2];
   end

   assign sclk_rise = pin_lvl_nxt[0] & ~pin_lvl_r[0];

   // Bus and control state
   reg  [7:0]  state_r;
   reg  [31:0] ctrl_r;
   reg         start_r;
   reg  [7:0]  ph_addr_r;
   reg         ph_wr_r;
   reg  [`SCG_ERR_BITS-1:0] err_r;
   reg  [31:0] words_r;
   reg  [7:0]  reject_cnt_r;
   reg         lock_r;
   reg         lock_cap_r;

   // Word assembler
   reg  [31:0] shift_r;
   reg  [4:0]  bitcnt_r;
   reg         pend_r;
   reg  [31:0] pend_word_r;
   wire [31:0] shift_nxt;
   wire        word_done;
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [31:0] fifo_out_data;
   wire        busy;
   wire        take;
   wire        accept;

   assign busy      = (state_r != ST_IDLE) & (state_r != ST_USER) & (state_r != ST_HALT);
   assign shift_nxt = {shift_r[30:0], pin_lvl_nxt[1]};
   assign word_done = busy & sclk_rise & (bitcnt_r == 5'h1f);
   assign accept    = pend_r & fifo_in_ready;
   assign take      = busy & fifo_out_valid;

   scg_fifo #(.W(32), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .flush     (start_r),
      .in_valid  (pend_r),
      .in_ready  (fifo_in_ready),
      .in_data   (pend_word_r),
      .out_valid (fifo_out_valid),
      .out_ready (busy),
      .out_data  (fifo_out_data)
   );

   // Serial link cannot stall, so a word held back a whole word time is an overrun
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_lvl_r   <= 3'h0;
         shift_r     <= 32'h00000000;
         bitcnt_r    <= 5'h00;
         pend_r      <= 1'b0;
         pend_word_r <= 32'h00000000;
      end else begin
         pin_lvl_r <= pin_lvl_nxt;
         if (start_r) begin
            bitcnt_r <= 5'h00;
            pend_r   <= 1'b0;
         end else begin
            if (busy & sclk_rise) begin
               shift_r  <= shift_nxt;
               bitcnt_r <= bitcnt_r + 1'b1;
            end
            if (word_done & (accept | ~pend_r)) begin
               pend_r      <= 1'b1;
               pend_word_r <= shift_nxt;
            end else if (accept) begin
               pend_r <= 1'b0;
            end
         end
      end
   end

   // Stream parsing and security checks
   reg         hdr_enc_r;
   reg         hdr_sign_r;
   reg  [31:0] remain_r;
   reg  [31:0] pk_r;
   reg  [31:0] dig_r;
   reg  [31:0] ks_cnt_r;
   wire [2:0]  width_code;
   wire        sec_on;
   wire        wide_bad;
   wire        comp_bad;
   wire        match_bad;
   wire [31:0] keystream;
   wire [31:0] plain;
   wire        ovf;

   assign width_code = ctrl_r[`SCG_CTRL_WID_HI:`SCG_CTRL_WID_LO];
   assign sec_on     = fifo_out_data[`SCG_HDR_ENC] | fifo_out_data[`SCG_HDR_SIGN];
   assign comp_bad   = sec_on & fifo_out_data[`SCG_HDR_COMP];
   assign wide_bad   = sec_on & ((width_code == `SCG_WID_X16) |
                                 (width_code == `SCG_WID_X32));
   assign match_bad  = (fifo_out_data[`SCG_HDR_ENC] != ctrl_r[`SCG_CTRL_ENC]) |
                       (fifo_out_data[`SCG_HDR_SIGN] != ctrl_r[`SCG_CTRL_AUTH]);
   assign keystream  = scg_mix(key_word(fuse_aes_key, ks_cnt_r[2:0]),
                               ks_cnt_r ^ key_word(fuse_aes_key, ~ks_cnt_r[2:0]));
   assign plain      = hdr_enc_r ? (fifo_out_data ^ keystream) : fifo_out_data;
   assign ovf        = word_done & pend_r & ~accept;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r        <= ST_IDLE;
         hdr_enc_r      <= 1'b0;
         hdr_sign_r     <= 1'b0;
         remain_r       <= 32'h00000000;
         pk_r           <= 32'h00000000;
         dig_r          <= 32'h00000000;
         ks_cnt_r       <= 32'h00000000;
         err_r          <= {`SCG_ERR_BITS{1'b0}};
         words_r        <= 32'h00000000;
         cfg_word       <= 32'h00000000;
         cfg_word_valid <= 1'b0;
         user_mode      <= 1'b0;
         cfg_halted     <= 1'b0;
      end else begin
         cfg_word_valid <= 1'b0;
         if (start_r & ~busy) begin
            state_r    <= ST_HDR;
            err_r      <= {`SCG_ERR_BITS{1'b0}};
            dig_r      <= `SCG_MIX_SEED;
            ks_cnt_r   <= 32'h00000000;
            words_r    <= 32'h00000000;
            user_mode  <= 1'b0;
            cfg_halted <= 1'b0;
         end else if (busy & ovf) begin
            state_r                <= ST_HALT;
            err_r[`SCG_ERR_OVF]    <= 1'b1;
            cfg_halted             <= 1'b1;
         end else if (take) begin
            case (state_r)
               ST_HDR: begin
                  hdr_enc_r  <= fifo_out_data[`SCG_HDR_ENC];
                  hdr_sign_r <= fifo_out_data[`SCG_HDR_SIGN];
                  if (comp_bad | wide_bad | match_bad) begin
                     state_r                  <= ST_HALT;
                     cfg_halted               <= 1'b1;
                     err_r[`SCG_ERR_COMP]     <= comp_bad;
                     err_r[`SCG_ERR_WIDE]     <= wide_bad;
                     err_r[`SCG_ERR_MISMATCH] <= match_bad;
                  end else begin
                     state_r <= ST_LEN;
                  end
               end
               ST_LEN: begin
                  remain_r <= fifo_out_data;
                  if (fifo_out_data == 32'h00000000) begin
                     state_r             <= ST_HALT;
                     cfg_halted          <= 1'b1;
                     err_r[`SCG_ERR_LEN] <= 1'b1;
                  end else begin
                     state_r <= hdr_sign_r ? ST_PKH : ST_DATA;
                  end
               end
               ST_PKH: begin
                  pk_r <= fifo_out_data;
                  if (scg_mix(`SCG_MIX_SEED, fifo_out_data) != fuse_pubkey_hash) begin
                     state_r             <= ST_HALT;
                     cfg_halted          <= 1'b1;
                     err_r[`SCG_ERR_PKH] <= 1'b1;
                  end else begin
                     state_r <= ST_DATA;
                  end
               end
               ST_DATA: begin
                  cfg_word       <= plain;
                  cfg_word_valid <= 1'b1;
                  words_r        <= words_r + 1'b1;
                  ks_cnt_r       <= ks_cnt_r + 1'b1;
                  dig_r          <= scg_mix(dig_r, plain);
                  remain_r       <= remain_r - 1'b1;
                  if (remain_r == 32'h00000001) begin
                     if (hdr_sign_r) begin
                        state_r <= ST_SIG;
                     end else begin
                        state_r   <= ST_USER;
                        user_mode <= 1'b1;
                     end
                  end
               end
               ST_SIG: begin
                  if (fifo_out_data == scg_mix(dig_r, pk_r)) begin
                     state_r   <= ST_USER;
                     user_mode <= 1'b1;
                  end else begin
                     state_r             <= ST_HALT;
                     cfg_halted          <= 1'b1;
                     err_r[`SCG_ERR_SIG] <= 1'b1;
                  end
               end
               default: begin
                  state_r <= ST_HALT;
               end
            endcase
         end
      end
   end

   // Lock latch: taken once after reset, no path ever clears it
   wire ir_allowed;

   assign ir_allowed = lock_cap_r & (~lock_r | is_public_ir(jtag_ir_code));

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_r         <= 1'b1;
         lock_cap_r     <= 1'b0;
         jtag_ir_active <= `SCG_JI_BYPASS;
         jtag_ir_reject <= 1'b0;
         reject_cnt_r   <= 8'h00;
      end else begin
         jtag_ir_reject <= 1'b0;
         if (!lock_cap_r) begin
            lock_r     <= fuse_jtag_lock;
            lock_cap_r <= 1'b1;
         end else begin
            lock_r <= lock_r | fuse_jtag_lock;
         end
         if (jtag_ir_update) begin
            if (ir_allowed) begin
               jtag_ir_active <= jtag_ir_code;
            end else begin
               jtag_ir_active <= `SCG_JI_BYPASS;
               jtag_ir_reject <= 1'b1;
               reject_cnt_r   <= reject_cnt_r + 1'b1;
            end
         end
      end
   end

   // AHB-Lite slave, zero wait states, read data registered in address phase
   wire        addr_ph;
   reg  [31:0] rd_mux;

   assign addr_ph = hsel & hready & htrans[1];

   always @* begin
      rd_mux = 32'h00000000;
      case (haddr[7:0])
         `SCG_REG_CTRL: begin
            rd_mux = ctrl_r;
         end
         `SCG_REG_STATUS: begin
            rd_mux[`SCG_ST_STATE_HI:`SCG_ST_STATE_LO] = state_r;
            rd_mux[`SCG_ST_USER]                      = user_mode;
            rd_mux[`SCG_ST_HALT]                      = cfg_halted;
            rd_mux[`SCG_ST_LOCK]                      = lock_r;
            rd_mux[`SCG_ST_SUPPLY]                    = pin_lvl_r[2];
            rd_mux[`SCG_ST_ERR_HI:`SCG_ST_ERR_LO]     = err_r;
         end
         `SCG_REG_JTAG: begin
            rd_mux[3:0]  = jtag_ir_active;
            rd_mux[4]    = lock_r;
            rd_mux[15:8] = reject_cnt_r;
         end
         `SCG_REG_WORDS: begin
            rd_mux = words_r;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hrdata    <= 32'h00000000;
         hresp     <= 1'b0;
         ph_addr_r <= 8'h00;
         ph_wr_r   <= 1'b0;
         ctrl_r    <= `SCG_CTRL_RESET;
         start_r   <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         start_r   <= 1'b0;
         ph_wr_r   <= addr_ph & hwrite;
         if (addr_ph) begin
            ph_addr_r <= haddr[7:0];
            if (!hwrite) begin
               hrdata <= rd_mux;
            end
         end
         // Settings are frozen while a stream is being parsed
         if (ph_wr_r & (ph_addr_r == `SCG_REG_CTRL) & ~busy) begin
            ctrl_r  <= hwdata & `SCG_CTRL_MASK;
            start_r <= hwdata[`SCG_CTRL_START];
         end
      end
   end

endmodule // scg_gate

`default_nettype wire

// File: scg_gate_properties.sv
`include "scg_regs.vh"
`default_nettype none

module scg_gate_chk (
   // Clock and reset
   input wire logic       hclk,
   input wire logic       hresetn,
   // Bus response
   input wire logic       hresp,
   // Lock fuse and test port decoder
   input wire logic       fuse_jtag_lock,
   input wire logic       jtag_ir_update,
   input wire logic [3:0] jtag_ir_code,
   input wire logic [3:0] jtag_ir_active,
   input wire logic       jtag_ir_reject,
   // Configuration side
   input wire logic       cfg_word_valid,
   input wire logic       user_mode,
   input wire logic       cfg_halted
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lk_r;
   logic first_r;
   wire  ok_code = jtag_ir_code == `SCG_JI_IDCODE || jtag_ir_code == `SCG_JI_STATUS ||
                   jtag_ir_code == `SCG_JI_BYPASS;

   // Lock seen as set until latched on the first edge, then sticky
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lk_r    <= 1'b1;
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
         lk_r    <= first_r ? fuse_jtag_lock : (lk_r | fuse_jtag_lock);
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   bus_okay_a: assert property (!hresp) else $error("error response seen");
   halt_excl_a: assert property (cfg_halted |-> !user_mode)
      else $error("user mode while halted");
   user_entry_a: assert property ($rose(user_mode) |-> !cfg_halted && !$past(cfg_halted))
      else $error("user mode entered from halt");
   halt_quiet_a: assert property (cfg_halted |-> !cfg_word_valid)
      else $error("word delivered while halted");
   lock_gate_a: assert property (jtag_ir_update && lk_r && !ok_code |=>
      jtag_ir_reject && jtag_ir_active == 4'hf) else $error("locked code accepted");
   lock_pass_a: assert property (jtag_ir_update && ok_code && !first_r |=>
      !jtag_ir_reject && jtag_ir_active == $past(jtag_ir_code))
      else $error("allowed code refused");
   open_decode_a: assert property (jtag_ir_update && !lk_r |=>
      !jtag_ir_reject && jtag_ir_active == $past(jtag_ir_code)) else $error("open code refused");
   reject_cause_a: assert property (jtag_ir_reject |-> $past(jtag_ir_update))
      else $error("reject without update");
   ir_hold_a: assert property (!$past(jtag_ir_update) |-> $stable(jtag_ir_active))
      else $error("instruction changed without update");
endmodule // scg_gate_chk

bind scg_gate scg_gate_chk chk_u (.hclk, .hresetn, .hresp, .fuse_jtag_lock, .jtag_ir_update,
   .jtag_ir_code, .jtag_ir_active, .jtag_ir_reject, .cfg_word_valid, .user_mode, .cfg_halted);

`default_nettype wire

// File: scg_link_src.sv
`default_nettype none

module scg_link_src (
   // Link pins
   output logic cfg_sclk,
   output logic cfg_sdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cfg_sclk  = 1'b0;
      cfg_sdata = 1'b1;
   end

   // Clock parked low between frames; data inverted so no stale bit reads valid
   task automatic send(input logic [31:0] w);
      #3;
      for (int i = 31; i >= 0; i--) begin
         cfg_sdata = w[i];
         #80 cfg_sclk = 1'b1;
         #80 cfg_sclk = 1'b0;
      end
      cfg_sdata = ~w[0];
   endtask
endmodule // scg_link_src

`default_nettype wire

// File: tb_scg_gate.sv
`include "scg_regs.vh"
`default_nettype none

module tb_scg_gate;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0]  SEED = `SCG_MIX_SEED;
   localparam logic [255:0] KEY  = {128'h0f1e2d3c4b5a6978_8796a5b4c3d2e1f0,
                                    128'h13579bdf2468ace0_55aa33cc0ff09669};
   localparam logic [31:0]  PK   = 32'h3c5a9e17;

   function automatic logic [31:0] mix(input logic [31:0] a, input logic [31:0] b);
      return {a[26:0], a[31:27]} ^ (b + {b[18:0], b[31:19]} + SEED);
   endfunction

   function automatic logic [31:0] ks(input logic [31:0] i);
      return mix(KEY[32*i[2:0] +: 32], i ^ KEY[32*(7-i[2:0]) +: 32]);
   endfunction

   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic        jtag_ir_update = 1'b0;
   logic [3:0]  jtag_ir_code = 4'h0;
   logic        fuse_jtag_lock = 1'b0;
   logic        fuse_program_supply = 1'b0;
   wire logic [255:0] fuse_aes_key = KEY;
   wire logic [31:0]  fuse_pubkey_hash = mix(SEED, PK);
   wire logic         hreadyout, hresp, cfg_sclk, cfg_sdata, cfg_word_valid;
   wire logic         user_mode, cfg_halted, jtag_ir_reject;
   wire logic [31:0]  hrdata, cfg_word;
   wire logic [3:0]   jtag_ir_active;
   int          bad_count = 0;
   int          cmp_count = 0;
   logic [31:0] got_q[$];
   logic [31:0] exp_q[$];
   logic [31:0] rd;

   always #4 hclk = ~hclk;

   scg_gate #(.FIFO_DEPTH(32), .FIFO_AW(5)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .cfg_sclk,
      .cfg_sdata, .fuse_aes_key, .fuse_pubkey_hash, .fuse_jtag_lock, .fuse_program_supply,
      .jtag_ir_update, .jtag_ir_code, .jtag_ir_active, .jtag_ir_reject, .cfg_word,
      .cfg_word_valid, .user_mode, .cfg_halted);

   scg_link_src src_u (.cfg_sclk, .cfg_sdata);

   always @(posedge hclk) begin
      if (cfg_word_valid === 1'b1) got_q.push_back(cfg_word);
   end

   task automatic results();
      $display("TB: compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic rst();
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask

   task automatic jt(input logic [3:0] c, input logic [3:0] ea, input logic er);
      @(posedge hclk);
      jtag_ir_update <= 1'b1;
      jtag_ir_code   <= c;
      @(posedge hclk);
      jtag_ir_update <= 1'b0;
      @(posedge hclk);
      chk({28'h0, jtag_ir_active}, {28'h0, ea});
      chk({31'h0, jtag_ir_reject}, {31'h0, er});
   endtask

   // Header-level faults stop after the first word, so nothing else is sent
   task automatic run(input logic [31:0] ctl, input logic [31:0] hdr, input int n,
                      input logic bad, input logic [31:0] st);
      logic [31:0] d;
      logic [31:0] p;
      d = SEED;
      got_q.delete();
      exp_q.delete();
      ahb(1'b1, `SCG_REG_CTRL, ctl | 32'h100, rd);
      src_u.send(hdr);
      if (st[18:16] == 3'b000) begin
         src_u.send(n);
         if (hdr[1]) src_u.send(PK);
         for (int i = 0; i < n; i++) begin
            p = 32'h0a000000 + i * 32'h01010101;
            d = mix(d, p);
            exp_q.push_back(p);
            src_u.send(hdr[0] ? p ^ ks(i) : p);
         end
         if (hdr[1]) src_u.send(mix(d, PK) ^ {31'h0, bad});
      end
      for (int k = 0; k < 100 && user_mode !== 1'b1 && cfg_halted !== 1'b1; k++) @(posedge hclk);
      ahb(1'b0, `SCG_REG_STATUS, 32'h0, rd);
      chk(rd, st);
      chk(got_q.size(), exp_q.size());
      foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
   endtask

   initial begin
      #400000;
      bad_count++;
      results();
   end

   initial begin
      rst();
      chk({28'h0, jtag_ir_active}, 32'hf);
      ahb(1'b0, `SCG_REG_STATUS, 32'h0, rd);
      chk(rd, 32'h1);
      ahb(1'b0, 8'h10, 32'h0, rd);
      chk(rd, 32'h0);
      run(32'h3, 32'h3, 3, 1'b0, 32'h140);
      ahb(1'b0, `SCG_REG_WORDS, 32'h0, rd);
      chk(rd, 32'h3);
      ahb(1'b0, `SCG_REG_CTRL, 32'h0, rd);
      chk(rd, 32'h3);
      run(32'h0, 32'h0, 0, 1'b0, 32'h00400280);
      run(32'h1, 32'h3, 0, 1'b0, 32'h00040280);
      run(32'h2, 32'h2, 2, 1'b0, 32'h140);
      run(32'h1, 32'h1, 2, 1'b0, 32'h140);
      run(32'h3, 32'h3, 2, 1'b1, 32'h00100280);
      run(32'h1, 32'h5, 0, 1'b0, 32'h00010280);
      for (int w = 4; w < 6; w++) run(32'h1 | (w << 4), 32'h1, 0, 1'b0, 32'h00020280);
      jt(4'h3, 4'h3, 1'b0);
      fuse_jtag_lock <= 1'b1;
      rst();
      fuse_program_supply <= 1'b1;
      repeat (6) @(posedge hclk);
      ahb(1'b0, `SCG_REG_STATUS, 32'h0, rd);
      chk(rd, 32'h00000c01);
      fuse_program_supply <= 1'b0;
      for (int c = 0; c < 16; c++) begin
         if (c == 1 || c == 2 || c == 15) jt(c, c, 1'b0);
         else jt(c, 4'hf, 1'b1);
      end
      fuse_jtag_lock <= 1'b0;
      ahb(1'b1, `SCG_REG_JTAG, 32'h0, rd);
      jt(4'h3, 4'hf, 1'b1);
      ahb(1'b0, `SCG_REG_JTAG, 32'h0, rd);
      chk(rd, 32'h00000e1f);
      results();
   end
endmodule // tb_scg_gate

`default_nettype wire
